// ===== include/clk_route_pkg.sv
package clk_route_pkg;

    // register offsets on the serial port
    localparam logic [7:0] ADDR_RSVD_A = 8'h22;
    localparam logic [7:0] ADDR_OUT_SEL = 8'h23;
    localparam logic [7:0] ADDR_PWR_SEL = 8'h24;

    // values after reset
    localparam logic [7:0] RST_RSVD_A = 8'hF4;
    localparam logic [7:0] RST_OUT_SEL = 8'h8D;
    localparam logic [7:0] RST_PWR_SEL = 8'h9B;
    // writable bits of the power/free-run byte; bit 4 is reserved
    localparam logic [7:0] PWR_SEL_WMASK = 8'hEF;

    // field positions
    localparam int unsigned OUT3_SEL_LSB = 6;
    localparam int unsigned OUT2_SEL_LSB = 4;
    localparam int unsigned OUT1_SEL_LSB = 2;
    localparam int unsigned FIRST_DIVIDER_SEL_LSB = 0;
    localparam int unsigned CHIP_RUN_BIT = 7;
    localparam int unsigned REF_FREE_BIT = 6;
    localparam int unsigned FREE_CFG_BIT = 5;
    localparam int unsigned PWR_RSVD_BIT = 4;
    localparam int unsigned OUT1_STOP_BIT = 3;
    localparam int unsigned DIV4_SEL_LSB = 0;

    // output source codes
    localparam logic [1:0] SEL_THIRD_DIV = 2'h0;
    localparam logic [1:0] SEL_FIFTH_DIV = 2'h1;
    localparam logic [1:0] SEL_FIRST_DIV = 2'h2;
    localparam logic [1:0] SEL_RTC = 2'h3;
    // first divider source codes (upper bit set picks the seed)
    localparam logic [1:0] FIRST_DIVIDER_SEL_PLL = 2'h0;
    localparam logic [1:0] FIRST_DIVIDER_SEL_REF = 2'h1;
    // fourth divider source codes
    localparam logic [1:0] DIV4_SEL_PLL2 = 2'h0;
    localparam logic [1:0] DIV4_SEL_PLL3 = 2'h1;
    localparam logic [1:0] DIV4_SEL_THIRD_DIVIDER = 2'h2;
    localparam logic [1:0] DIV4_SEL_FIFTH_DIVIDER = 2'h3;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // arbitrary default serial address
    localparam logic [6:0] DEF_DEV_ADDR = 7'h55;

    typedef struct packed {
        logic first_pll;
        logic reference;
        logic fourth_divider_seed_out;
        logic second_pll_channel_two;
        logic third_pll_channel_two;
        logic third_divider_seed;
        logic fifth_divider_seed;
        logic third_divider;
        logic fifth_divider;
        logic first_divider;
        logic low_power_rtc_clock;
    } src_clocks_s;

    typedef struct packed {
        logic out1;
        logic out2;
        logic out3;
        logic first_div_src;
        logic fourth_div_src;
    } route_out_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_REG = 4'h3,
        ST_REG_ACK = 4'h4,
        ST_WDATA = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA = 4'h7,
        ST_RDATA_ACK = 4'h8
    } serial_state_e;

endpackage

// ===== verilog/output_clock_routing_ctrl.sv
`timescale 1ns/1ps

module output_clock_routing_ctrl
    import clk_route_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEF_DEV_ADDR
) (
    input wire CLK_SYS,
    input wire RST_N,
    input src_clocks_s SRC_CLOCKS,
    input wire SCL,
    input wire SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    output route_out_s ROUTED,
    output logic CHIP_POWER_DOWN_N,
    output logic OUT3_FREE_RUN
);

    function automatic logic out_mux(input logic [1:0] sel,
                                     input src_clocks_s c);
        case (sel)
            SEL_THIRD_DIV: out_mux = c.third_divider;
            SEL_FIFTH_DIV: out_mux = c.fifth_divider;
            SEL_FIRST_DIV: out_mux = c.first_divider;
            default: out_mux = c.low_power_rtc_clock;
        endcase
    endfunction

    function automatic logic [7:0] reg_read(input logic [7:0] a,
                                            input logic [7:0] osel,
                                            input logic [7:0] pwr);
        case (a)
            ADDR_RSVD_A: reg_read = RST_RSVD_A;
            ADDR_OUT_SEL: reg_read = osel;
            ADDR_PWR_SEL: reg_read = pwr;
            default: reg_read = 8'h00;
        endcase
    endfunction

    // clock sources are sampled: adequate for slow outputs only
    src_clocks_s src_meta_reg, src_sync_reg;
    route_out_s routed_reg, routed_next;
    logic sel_out1, sel_out2, sel_out3, sel_first_divider, sel_div4;
    logic run1, run2, run3, chip_run;

    serial_state_e state_reg, state_next;
    logic scl_meta_reg, scl_sync_reg, scl_dly_reg;
    logic sda_meta_reg, sda_sync_reg, sda_dly_reg;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] ptr_reg, ptr_next;
    logic [7:0] out_sel_reg, out_sel_next;
    logic [7:0] pwr_reg, pwr_next;
    logic rw_reg, rw_next;
    logic oe_reg, oe_next;
    logic sda_out_reg;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    logic [7:0] rd_byte;

    always_comb begin
        sel_out1 = out_mux(out_sel_reg[OUT1_SEL_LSB +: 2],
                           src_sync_reg);
        sel_out2 = out_mux(out_sel_reg[OUT2_SEL_LSB +: 2],
                           src_sync_reg);
        sel_out3 = out_mux(out_sel_reg[OUT3_SEL_LSB +: 2],
                           src_sync_reg);
        case (out_sel_reg[FIRST_DIVIDER_SEL_LSB +: 2])
            FIRST_DIVIDER_SEL_PLL: sel_first_divider = src_sync_reg.first_pll;
            FIRST_DIVIDER_SEL_REF: sel_first_divider = src_sync_reg.reference;
            default: sel_first_divider = src_sync_reg.fourth_divider_seed_out;
        endcase
        case (pwr_reg[DIV4_SEL_LSB +: 2])
            DIV4_SEL_PLL2: sel_div4 = src_sync_reg.second_pll_channel_two;
            DIV4_SEL_PLL3: sel_div4 = src_sync_reg.third_pll_channel_two;
            DIV4_SEL_THIRD_DIVIDER: sel_div4 = src_sync_reg.third_divider_seed;
            DIV4_SEL_FIFTH_DIVIDER: sel_div4 = src_sync_reg.fifth_divider_seed;
            default: sel_div4 = 1'b0;
        endcase
        // in power down only free-running outputs keep toggling
        chip_run = pwr_reg[CHIP_RUN_BIT];
        run1 = chip_run | ~pwr_reg[OUT1_STOP_BIT];
        run2 = chip_run | pwr_reg[REF_FREE_BIT];
        run3 = chip_run | (run2 & pwr_reg[FREE_CFG_BIT]);
        routed_next.out1 = sel_out1 & run1;
        routed_next.out2 = sel_out2 & run2;
        routed_next.out3 = sel_out3 & run3;
        routed_next.first_div_src = sel_first_divider & chip_run;
        routed_next.fourth_div_src = sel_div4 & chip_run;
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            src_meta_reg <= '0;
            src_sync_reg <= '0;
            routed_reg <= '0;
        end else begin
            src_meta_reg <= SRC_CLOCKS;
            src_sync_reg <= src_meta_reg;
            routed_reg <= routed_next;
        end
    end

    assign scl_rise = scl_sync_reg & ~scl_dly_reg;
    assign scl_fall = ~scl_sync_reg & scl_dly_reg;
    assign bus_start = scl_sync_reg & scl_dly_reg & sda_dly_reg & ~sda_sync_reg;
    assign bus_stop = scl_sync_reg & scl_dly_reg & ~sda_dly_reg & sda_sync_reg;
    assign rd_byte = reg_read(ptr_reg, out_sel_reg, pwr_reg);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        out_sel_next = out_sel_reg;
        pwr_next = pwr_reg;
        rw_next = rw_reg;
        oe_next = oe_reg;
        if (bus_start) begin
            state_next = ST_ADDR;
            cnt_next = 4'h0;
            oe_next = 1'b0;
        end else if (bus_stop) begin
            state_next = ST_IDLE;
            oe_next = 1'b0;
        end else begin
            case (state_reg)
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_sync_reg};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == BITS_PER_BYTE) begin
                        cnt_next = 4'h0;
                        oe_next = 1'b1;
                        if (state_reg == ST_ADDR) begin
                            rw_next = shift_reg[0];
                            state_next = ST_ADDR_ACK;
                            if (shift_reg[7:1] != DEV_ADDR) begin
                                oe_next = 1'b0;
                                state_next = ST_IDLE;
                            end
                        end else if (state_reg == ST_REG) begin
                            ptr_next = shift_reg;
                            state_next = ST_REG_ACK;
                        end else begin
                            if (ptr_reg == ADDR_OUT_SEL) begin
                                out_sel_next = shift_reg;
                            end
                            if (ptr_reg == ADDR_PWR_SEL) begin
                                pwr_next = (shift_reg & PWR_SEL_WMASK)
                                    | (RST_PWR_SEL & ~PWR_SEL_WMASK);
                            end
                            ptr_next = ptr_reg + 8'h01;
                            state_next = ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_reg) begin
                            shift_next = rd_byte;
                            oe_next = ~rd_byte[7];
                            ptr_next = ptr_reg + 8'h01;
                            state_next = ST_RDATA;
                        end else begin
                            oe_next = 1'b0;
                            state_next = ST_REG;
                        end
                    end
                end
                ST_REG_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        oe_next = 1'b0;
                        state_next = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_reg == BITS_PER_BYTE) begin
                            cnt_next = 4'h0;
                            oe_next = 1'b0;
                            state_next = ST_RDATA_ACK;
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            oe_next = ~shift_reg[6];
                        end
                    end
                end
                ST_RDATA_ACK: begin
                    if (scl_rise && sda_sync_reg) begin
                        state_next = ST_IDLE;
                    end else if (scl_fall) begin
                        shift_next = rd_byte;
                        oe_next = ~rd_byte[7];
                        ptr_next = ptr_reg + 8'h01;
                        state_next = ST_RDATA;
                    end
                end
                default: begin
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            scl_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            scl_dly_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
            sda_dly_reg <= 1'b1;
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            out_sel_reg <= RST_OUT_SEL;
            pwr_reg <= RST_PWR_SEL;
            rw_reg <= 1'b0;
            oe_reg <= 1'b0;
            sda_out_reg <= 1'b0;
        end else begin
            scl_meta_reg <= SCL;
            scl_sync_reg <= scl_meta_reg;
            scl_dly_reg <= scl_sync_reg;
            sda_meta_reg <= SDA_IN;
            sda_sync_reg <= sda_meta_reg;
            sda_dly_reg <= sda_sync_reg;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            out_sel_reg <= out_sel_next;
            pwr_reg <= pwr_next;
            rw_reg <= rw_next;
            oe_reg <= oe_next;
            sda_out_reg <= 1'b0;
        end
    end

    assign ROUTED = routed_reg;
    assign SDA_OE = oe_reg;
    assign SDA_OUT = sda_out_reg;
    assign CHIP_POWER_DOWN_N = pwr_reg[CHIP_RUN_BIT];
    assign OUT3_FREE_RUN = pwr_reg[FREE_CFG_BIT];

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    a_out1_route: assert property (
        $past(pwr_reg[CHIP_RUN_BIT]) |-> ROUTED.out1 == $past(sel_out1))
        else $error("first output not on its selected source");
    a_out3_rtc: assert property (
        $past(out_sel_reg[7:6] == SEL_RTC && pwr_reg[CHIP_RUN_BIT])
        |-> ROUTED.out3 == $past(src_sync_reg.low_power_rtc_clock))
        else $error("third output not on rtc clock");
    a_first_divider_seed: assert property (
        $past(out_sel_reg[1] && pwr_reg[CHIP_RUN_BIT])
        |-> ROUTED.first_div_src
            == $past(src_sync_reg.fourth_divider_seed_out))
        else $error("first divider not fed from seed");
    a_div4_seed: assert property (
        $past(pwr_reg[1:0] == DIV4_SEL_THIRD_DIVIDER && pwr_reg[CHIP_RUN_BIT])
        |-> ROUTED.fourth_div_src == $past(src_sync_reg.third_divider_seed))
        else $error("fourth divider not fed from third seed");
    a_power_down: assert property (
        !pwr_reg[CHIP_RUN_BIT] ##1 !pwr_reg[CHIP_RUN_BIT]
        |-> !ROUTED.first_div_src && !ROUTED.fourth_div_src)
        else $error("divider sources run in power down");
    a_out3_stop: assert property (
        $past(!pwr_reg[CHIP_RUN_BIT] && !pwr_reg[FREE_CFG_BIT])
        |-> !ROUTED.out3)
        else $error("third output runs though not free-run");
    a_reserved_hold: assert property (
        state_reg == ST_ADDR_ACK && rw_reg && scl_fall
        && ptr_reg == ADDR_RSVD_A
        |=> shift_reg == RST_RSVD_A && pwr_reg[PWR_RSVD_BIT])
        else $error("reserved bits lost their values");
    a_reg_ack: assert property (
        state_reg == ST_REG && scl_fall && cnt_reg == BITS_PER_BYTE
        && !bus_start && !bus_stop |=> SDA_OE ##0 state_reg == ST_REG_ACK)
        else $error("offset byte not acknowledged");

endmodule

// ===== bench/output_clock_routing_ctrl_tb_top.sv
`timescale 1ns/1ps

module output_clock_routing_ctrl_tb_top
    import clk_route_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl = 1'b1;
    logic sda_m = 1'b1;
    src_clocks_s src = '0;
    logic sda_out;
    logic sda_oe;
    logic pd_n;
    logic out3_fr;
    route_out_s routed;
    int errors = 0;
    int checks = 0;
    // open-drain wire: the device can only pull low
    wire sda_line = sda_oe ? 1'b0 : sda_m;

    always #4 clk = ~clk;

    output_clock_routing_ctrl i_output_clock_routing_ctrl (
        .CLK_SYS(clk),
        .RST_N(rst_n),
        .SRC_CLOCKS(src),
        .SCL(scl),
        .SDA_IN(sda_line),
        .SDA_OUT(sda_out),
        .SDA_OE(sda_oe),
        .ROUTED(routed),
        .CHIP_POWER_DOWN_N(pd_n),
        .OUT3_FREE_RUN(out3_fr)
    );

    task automatic results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask

    // levels held 8 clocks so the 3-clock input sync never misses an edge
    task automatic start_cond;
        sda_m = 1'b1;
        hold(8);
        scl = 1'b1;
        hold(8);
        sda_m = 1'b0;
        hold(8);
        scl = 1'b0;
        hold(8);
    endtask

    task automatic stop_cond;
        sda_m = 1'b0;
        hold(8);
        scl = 1'b1;
        hold(8);
        sda_m = 1'b1;
        hold(8);
    endtask

    task automatic clk_bit(input logic b, output logic s);
        sda_m = b;
        hold(8);
        scl = 1'b1;
        hold(4);
        s = sda_line;
        hold(4);
        scl = 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] d, input logic ack_exp);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], s);
        end
        clk_bit(1'b1, s);
        chk("ack", {7'h0, ~ack_exp}, {7'h0, s});
    endtask

    task automatic get_byte(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d[i] = s;
        end
        // master nack ends the read
        clk_bit(1'b1, s);
    endtask

    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        start_cond;
        send_byte({DEF_DEV_ADDR, 1'b0}, 1'b1);
        send_byte(off, 1'b1);
        send_byte(d, 1'b1);
        stop_cond;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] off,
                          input logic [7:0] exp);
        logic [7:0] d;
        start_cond;
        send_byte({DEF_DEV_ADDR, 1'b0}, 1'b1);
        send_byte(off, 1'b1);
        start_cond;
        send_byte({DEF_DEV_ADDR, 1'b1}, 1'b1);
        get_byte(d);
        stop_cond;
        chk(what, exp, d);
    endtask

    // one source high at a time shows exactly which input each mux took
    task automatic route_chk(input string what, input logic [10:0] s,
                             input logic [4:0] exp);
        src = src_clocks_s'(s);
        hold(8);
        chk(what, {3'h0, exp}, {3'h0, routed});
    endtask

    initial begin
        hold(60000);
        errors++;
        $display("wrong value run time expected end seen hang");
        results;
    end

    initial begin
        logic [1:0] c;
        hold(16);
        rst_n = 1'b1;
        hold(2);
        rd_chk("reserved byte", ADDR_RSVD_A, RST_RSVD_A);
        rd_chk("output select", ADDR_OUT_SEL, RST_OUT_SEL);
        rd_chk("power byte", ADDR_PWR_SEL, RST_PWR_SEL);
        chk("power pin", 8'h01, {7'h0, pd_n});
        chk("free run pin", 8'h00, {7'h0, out3_fr});
        start_cond;
        send_byte({~DEF_DEV_ADDR, 1'b0}, 1'b0);
        stop_cond;
        rd_chk("unmapped byte", 8'h30, 8'h00);
        chk("sda out", 8'h00, {7'h0, sda_out});
        $display("reset and access test done");
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            wr(ADDR_OUT_SEL, {c, c, c, 2'h0});
            for (int k = 0; k < 4; k++) begin
                route_chk("output source", 11'h1 << k,
                          (k == 3 - i) ? 5'h1C : 5'h00);
            end
        end
        $display("output source test done");
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            wr(ADDR_OUT_SEL, {6'h0, c});
            for (int k = 8; k < 11; k++) begin
                route_chk("first divider source", 11'h1 << k,
                          (k == (c[1] ? 8 : 10 - i)) ? 5'h02 : 5'h00);
            end
            wr(ADDR_PWR_SEL, {6'h26, c});
            for (int k = 4; k < 8; k++) begin
                route_chk("fourth divider source", 11'h1 << k,
                          (k == 7 - i) ? 5'h01 : 5'h00);
            end
        end
        $display("divider source test done");
        wr(ADDR_OUT_SEL, 8'h00);
        wr(ADDR_PWR_SEL, 8'h1B);
        route_chk("powered down", 11'h7FF, 5'h00);
        chk("power pin", 8'h00, {7'h0, pd_n});
        wr(ADDR_PWR_SEL, 8'h68);
        route_chk("free run both", 11'h7FF, 5'h0C);
        chk("free run pin", 8'h01, {7'h0, out3_fr});
        wr(ADDR_PWR_SEL, 8'h48);
        route_chk("free run second", 11'h7FF, 5'h08);
        chk("free run pin", 8'h00, {7'h0, out3_fr});
        wr(ADDR_PWR_SEL, 8'h20);
        route_chk("free run first only", 11'h7FF, 5'h10);
        wr(ADDR_PWR_SEL, 8'hE8);
        rd_chk("power byte", ADDR_PWR_SEL, 8'hF8);
        route_chk("running", 11'h7FF, 5'h1F);
        chk("power pin", 8'h01, {7'h0, pd_n});
        wr(ADDR_RSVD_A, 8'h00);
        rd_chk("reserved byte", ADDR_RSVD_A, RST_RSVD_A);
        $display("power and free run test done");
        rst_n = 1'b0;
        hold(4);
        chk("reset routing", 8'h00, {3'h0, routed});
        chk("reset power pin", 8'h01, {7'h0, pd_n});
        rst_n = 1'b1;
        hold(2);
        rd_chk("output select", ADDR_OUT_SEL, RST_OUT_SEL);
        rd_chk("power byte", ADDR_PWR_SEL, RST_PWR_SEL);
        $display("mid-run reset test done");
        results;
    end
endmodule
